// ==== design/tlic_map.svh ====
// Register offsets, field positions, reset values and counts of the top-level interrupt block
`ifndef TLIC_MAP_SVH
`define TLIC_MAP_SVH
`define TLIC_ADDR_W 32
`define TLIC_NSRC 17
`define TLIC_OFF_PEND_SET 32'hE000E200
`define TLIC_OFF_PEND_CLR 32'hE000E280
`define TLIC_OFF_ACTIVE 32'hE000E300
`define TLIC_OFF_MISSED 32'h4000A820
`define TLIC_OFF_AFSR 32'hE000ED3C
`define TLIC_OFF_EVT_STAT 32'hE000EF00
`define TLIC_OFF_EVT_MASK 32'hE000EF04
`define TLIC_SRC_MASK 32'h0001FFFF
`define TLIC_MISS_MASK 32'h0000FFFC
`define TLIC_AFSR_MASK 32'h0000000F
`define TLIC_EVT_MASK_BITS 32'h00000007
`define TLIC_BIT_WIDTH 3
`define TLIC_BIT_PRIV 2
`define TLIC_BIT_UNMAP 1
`define TLIC_BIT_REPEAT 0
`define TLIC_EVT_FAULT 0
`define TLIC_EVT_MISS 1
`define TLIC_EVT_PEND 2
`define TLIC_RESET_VAL 32'h00000000
`endif

// ==== design/tlic_pkg.sv ====
// Types shared by the top-level interrupt block
package tlic_pkg;
   typedef struct packed {
      logic valid;
      logic narrow;
      logic unaligned;
      logic unpriv_wr;
      logic beyond_regs;
      logic beyond_mem;
   } tlic_fault_s;

   typedef enum logic [1:0] {
      TLIC_IDLE = 2'b00,
      TLIC_ACK = 2'b01
   } tlic_bus_e;
endpackage : tlic_pkg

// ==== design/tlic_sync.sv ====
// Two-flop synchroniser for asynchronous interrupt source levels
`timescale 1ns/1ps
module tlic_sync #(
   parameter int W = 17
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : tlic_sync

// ==== design/tlic_fault.sv ====
// Auxiliary bus-fault status register with cause decode and repeat flag
`timescale 1ns/1ps
`include "tlic_map.svh"
module tlic_fault (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire tlic_pkg::tlic_fault_s fault_i,
   input wire logic clr_i,
   input wire logic [3:0] clr_bits_i,
   output logic [3:0] afsr_o,
   output logic fault_evt_o
);
   logic [3:0] set_bits;

   always_comb begin
      set_bits = 4'h0;
      if (fault_i.valid) begin
         set_bits[`TLIC_BIT_WIDTH] = fault_i.narrow | fault_i.unaligned;
         set_bits[`TLIC_BIT_PRIV] = fault_i.unpriv_wr;
         set_bits[`TLIC_BIT_UNMAP] = fault_i.beyond_regs | fault_i.beyond_mem;
         set_bits[`TLIC_BIT_REPEAT] = |afsr_o;
      end
   end

   // Set wins over a same-cycle software clear so no cause is lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         afsr_o <= 4'h0;
      end else begin
         afsr_o <= (afsr_o & ~(clr_i ? clr_bits_i : 4'h0)) | set_bits;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_evt_o <= 1'b0;
      end else begin
         fault_evt_o <= fault_i.valid;
      end
   end
endmodule : tlic_fault

// ==== design/tlic_top.sv ====
// Top-level interrupt pending, active, missed and bus-fault status with a Wishbone slave
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "tlic_map.svh"
module tlic_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic [16:0] src_irq_i,
   input wire logic [16:0] src_active_i,
   input wire tlic_pkg::tlic_fault_s fault_i,
   output logic [16:0] pending_o,
   output logic irq_o
);
   logic [16:0] src_sync;
   logic [16:0] src_prev_q;
   logic [16:0] src_rise;
   logic [16:0] active_sync;
   logic [16:0] pending_q;
   logic [15:2] missed_q;
   logic [3:0] afsr;
   logic fault_evt;
   logic [2:0] evt_stat_q;
   logic [2:0] evt_mask_q;
   logic [2:0] evt_set;
   logic [31:0] wmask;
   logic [31:0] wr_ones;
   logic bus_req;
   logic bus_wr;
   logic hit_set;
   logic hit_clr;
   logic hit_act;
   logic hit_miss;
   logic hit_afsr;
   logic hit_stat;
   logic hit_mask;
   logic hit_any;
   logic [31:0] rd_data;
   tlic_pkg::tlic_bus_e bus_state_q;

   // Sources and active levels come from other blocks' clocks, so both pass two flops
   tlic_sync #(.W(`TLIC_NSRC)) u_src_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(src_irq_i),
      .q_o(src_sync)
   );

   tlic_sync #(.W(`TLIC_NSRC)) u_act_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(src_active_i),
      .q_o(active_sync)
   );

   tlic_fault u_fault (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .fault_i(fault_i),
      .clr_i(bus_wr & hit_afsr),
      .clr_bits_i(wr_ones[3:0]),
      .afsr_o(afsr),
      .fault_evt_o(fault_evt)
   );

   // Byte lane mask from sel
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
      end
   endgenerate

   assign wr_ones = wb_dat_i & wmask;
   assign bus_req = wb_cyc_i & wb_stb_i & (bus_state_q == tlic_pkg::TLIC_IDLE);
   assign hit_set = (wb_adr_i == `TLIC_OFF_PEND_SET);
   assign hit_clr = (wb_adr_i == `TLIC_OFF_PEND_CLR);
   assign hit_act = (wb_adr_i == `TLIC_OFF_ACTIVE);
   assign hit_miss = (wb_adr_i == `TLIC_OFF_MISSED);
   assign hit_afsr = (wb_adr_i == `TLIC_OFF_AFSR);
   assign hit_stat = (wb_adr_i == `TLIC_OFF_EVT_STAT);
   assign hit_mask = (wb_adr_i == `TLIC_OFF_EVT_MASK);
   assign hit_any = hit_set | hit_clr | hit_act | hit_miss | hit_afsr | hit_stat | hit_mask;
   // A write takes effect once, on the edge that raises ack
   assign bus_wr = bus_req & wb_we_i & hit_any;

   assign src_rise = src_sync & ~src_prev_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_prev_q <= 17'h00000;
      end else begin
         src_prev_q <= src_sync;
      end
   end

   // A rising source edge pends; software set pends; software clear drops.
   // New edges win over a same-cycle clear so no request is lost.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pending_q <= 17'h00000;
      end else begin
         pending_q <= (pending_q
                       & ~((bus_wr & hit_clr) ? wr_ones[16:0] : 17'h00000))
                      | ((bus_wr & hit_set) ? wr_ones[16:0] : 17'h00000)
                      | src_rise;
      end
   end

   // A rising edge on source 2 to 15 while it is still pending is a lost interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         missed_q <= 14'h0000;
      end else begin
         missed_q <= (missed_q & ~((bus_wr & hit_miss) ? wr_ones[15:2] : 14'h0000))
                     | (src_rise[15:2] & pending_q[15:2]);
      end
   end

   assign evt_set[`TLIC_EVT_FAULT] = fault_evt;
   assign evt_set[`TLIC_EVT_MISS] = |(src_rise[15:2] & pending_q[15:2]);
   assign evt_set[`TLIC_EVT_PEND] = |src_rise;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_stat_q <= 3'h0;
      end else begin
         evt_stat_q <= (evt_stat_q & ~((bus_wr & hit_stat) ? wr_ones[2:0] : 3'h0)) | evt_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_mask_q <= 3'h0;
      end else if (bus_wr & hit_mask) begin
         evt_mask_q <= (evt_mask_q & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         pending_o <= 17'h00000;
      end else begin
         irq_o <= |(evt_stat_q & evt_mask_q);
         pending_o <= pending_q;
      end
   end

   // Set and clear registers read back the pending state
   always_comb begin
      rd_data = `TLIC_RESET_VAL;
      if (hit_set | hit_clr) begin
         rd_data = {15'h0000, pending_q};
      end else if (hit_act) begin
         rd_data = {15'h0000, active_sync};
      end else if (hit_miss) begin
         rd_data = {16'h0000, missed_q, 2'h0};
      end else if (hit_afsr) begin
         rd_data = {28'h0000000, afsr};
      end else if (hit_stat) begin
         rd_data = {29'h00000000, evt_stat_q};
      end else if (hit_mask) begin
         rd_data = {29'h00000000, evt_mask_q};
      end
   end

   // One-cycle answer: ack for a mapped address, err otherwise; dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_q <= tlic_pkg::TLIC_IDLE;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         case (bus_state_q)
            tlic_pkg::TLIC_IDLE: begin
               wb_ack_o <= bus_req & hit_any;
               wb_err_o <= bus_req & ~hit_any;
               wb_dat_o <= (bus_req & ~wb_we_i) ? rd_data : 32'h00000000;
               if (bus_req) begin
                  bus_state_q <= tlic_pkg::TLIC_ACK;
               end
            end
            tlic_pkg::TLIC_ACK: begin
               wb_ack_o <= 1'b0;
               wb_err_o <= 1'b0;
               bus_state_q <= tlic_pkg::TLIC_IDLE;
            end
            default: begin
               wb_ack_o <= 1'b0;
               wb_err_o <= 1'b0;
               bus_state_q <= tlic_pkg::TLIC_IDLE;
            end
         endcase
      end
   end
endmodule : tlic_top

// ==== bench/tlic_src_model.sv ====
// Model of the interrupt sources and the bus fabric's fault reporter
`timescale 1ns/1ps
module tlic_src_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [16:0] lvl_i,
   input wire logic [16:0] act_i,
   input wire logic [4:0] cause_i,
   input wire logic fire_i,
   output logic [16:0] src_irq_o,
   output logic [16:0] src_active_o,
   output tlic_pkg::tlic_fault_s fault_o
);
   // The fabric reports each fault as a single-cycle pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_irq_o <= 17'h0;
         src_active_o <= 17'h0;
         fault_o <= 6'h00;
      end else begin
         src_irq_o <= lvl_i;
         src_active_o <= act_i;
         fault_o <= fire_i ? {1'b1, cause_i} : 6'h00;
      end
   end
endmodule : tlic_src_model

// ==== bench/tlic_top_sva.sv ====
// Bus handshake and pending-state assertions for the interrupt block
`timescale 1ns/1ps
`include "tlic_map.svh"
module tlic_top_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic [16:0] pending_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence wr_s(a);
      wb_ack_o && wb_we_i && wb_sel_i == 4'hF && wb_adr_i == a;
   endsequence
   sequence rd_s(a);
      wb_ack_o && !wb_we_i && wb_adr_i == a;
   endsequence
   bus_answer_a: assert property (take_s |=> (wb_ack_o || wb_err_o)) else $error("no answer");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
   err_data_a: assert property (wb_err_o |-> wb_dat_o == 32'h0 && !wb_ack_o) else $error("err data");
   pend_clear_a: assert property (wr_s(`TLIC_OFF_PEND_CLR) |=>
      (pending_o & $past(wb_dat_i[16:0])) == 17'h0) else $error("clear lost");
   pend_keep_a: assert property (wr_s(`TLIC_OFF_PEND_CLR) |=>
      ($past(pending_o) & ~$past(wb_dat_i[16:0]) & ~pending_o) == 17'h0) else $error("zero cleared");
   pend_set_a: assert property (wr_s(`TLIC_OFF_PEND_SET) |=>
      (pending_o & $past(wb_dat_i[16:0])) == $past(wb_dat_i[16:0])) else $error("set lost");
   active_width_a: assert property (rd_s(`TLIC_OFF_ACTIVE) |-> wb_dat_o[31:17] == 15'h0)
      else $error("active high bits");
   missed_width_a: assert property (rd_s(`TLIC_OFF_MISSED) |-> (wb_dat_o & ~`TLIC_MISS_MASK) == 32'h0)
      else $error("missed bits");
   pend_reset_a: assert property ($fell(rst_i) |-> pending_o == 17'h0) else $error("pending after reset");
endmodule : tlic_top_sva

// ==== bench/tlic_top_test.sv ====
// Self-checking bench for the interrupt block
`timescale 1ns/1ps
`include "tlic_map.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module tlic_top_test;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0, ack, err, irq, last_err;
   logic [31:0] adr = 32'h0, wdat = 32'h0, q, dat_o;
   logic [16:0] lvl = 17'h0, act = 17'h0, src_irq, src_act, pend;
   logic [4:0] cause = 5'h0;
   tlic_pkg::tlic_fault_s flt;
   int err_total = 0;
   int samples_checked = 0;
   tlic_src_model tlic_src_model_inst (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(lvl), .act_i(act), .cause_i(cause),
      .fire_i(fire), .src_irq_o(src_irq), .src_active_o(src_act), .fault_o(flt));
   tlic_top tlic_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
      .src_irq_i(src_irq), .src_active_i(src_act), .fault_i(flt), .pending_o(pend), .irq_o(irq));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
      q = dat_o;
      last_err = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string n);
      bus(1'b0, a, 32'h0);
      `CHK(n, e, q)
   endtask : rd_chk
   // Fault pulse needs the model's register plus the status update before a read
   task automatic hit(input logic [4:0] c);
      cause <= c;
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      tick(3);
   endtask : hit
   task automatic t_reset;
      rd_chk(`TLIC_OFF_PEND_CLR, `TLIC_RESET_VAL, "pending");
      rd_chk(`TLIC_OFF_ACTIVE, `TLIC_RESET_VAL, "active");
      rd_chk(`TLIC_OFF_MISSED, `TLIC_RESET_VAL, "missed");
      rd_chk(`TLIC_OFF_AFSR, `TLIC_RESET_VAL, "fault");
      bus(1'b0, 32'hE000E000, 32'h0);
      `CHK("unmapped", 1'b1, last_err)
   endtask : t_reset
   task automatic t_pend;
      logic [31:0] e;
      e = `TLIC_SRC_MASK;
      bus(1'b1, `TLIC_OFF_PEND_SET, 32'hFFFFFFFF);
      rd_chk(`TLIC_OFF_PEND_SET, e, "set all");
      for (int i = 0; i < 17; i++) begin
         bus(1'b1, `TLIC_OFF_PEND_CLR, 32'h1 << i);
         e[i] = 1'b0;
         rd_chk(`TLIC_OFF_PEND_CLR, e, "clear one");
      end
   endtask : t_pend
   task automatic t_active;
      act <= 17'h1A5C3;
      tick(6);
      rd_chk(`TLIC_OFF_ACTIVE, 32'h0001A5C3, "active");
      bus(1'b1, `TLIC_OFF_ACTIVE, 32'h0);
      rd_chk(`TLIC_OFF_ACTIVE, 32'h0001A5C3, "active ro");
   endtask : t_active
   // Second rise while still pending is the lost event; bits 0 and 16 have no flag
   task automatic t_miss;
      lvl <= 17'h10005;
      tick(8);
      lvl <= 17'h0;
      tick(8);
      lvl <= 17'h10005;
      tick(30);
      rd_chk(`TLIC_OFF_MISSED, 32'h00000004, "missed");
      bus(1'b1, `TLIC_OFF_MISSED, 32'hFFFFFFFF);
      rd_chk(`TLIC_OFF_MISSED, 32'h0, "missed clr");
   endtask : t_miss
   task automatic t_fault;
      logic [31:0] e [5] = '{32'h8, 32'h8, 32'h4, 32'h2, 32'h2};
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, `TLIC_OFF_AFSR, 32'hF);
         hit(5'h10 >> i);
         rd_chk(`TLIC_OFF_AFSR, e[i], "cause");
         hit(5'h10 >> i);
         rd_chk(`TLIC_OFF_AFSR, e[i] | 32'h1, "repeat");
      end
   endtask : t_fault
   task automatic t_irq;
      bus(1'b1, `TLIC_OFF_EVT_STAT, 32'h7);
      bus(1'b1, `TLIC_OFF_EVT_MASK, 32'h0);
      hit(5'h04);
      `CHK("masked irq", 1'b0, irq)
      bus(1'b1, `TLIC_OFF_EVT_MASK, 32'h1);
      tick(2);
      `CHK("irq on", 1'b1, irq)
      bus(1'b1, `TLIC_OFF_EVT_STAT, 32'h1);
      tick(2);
      `CHK("irq off", 1'b0, irq)
      // Source 1 rises fresh: only the new-pending event may raise the line
      bus(1'b1, `TLIC_OFF_EVT_MASK, 32'h2);
      lvl <= 17'h10007;
      tick(8);
      `CHK("miss irq idle", 1'b0, irq)
      bus(1'b1, `TLIC_OFF_EVT_MASK, 32'h4);
      tick(2);
      `CHK("pend irq", 1'b1, irq)
      // Source 2 is still pending, so its next rise is a lost event
      bus(1'b1, `TLIC_OFF_EVT_STAT, 32'h7);
      bus(1'b1, `TLIC_OFF_EVT_MASK, 32'h2);
      lvl <= 17'h10003;
      tick(8);
      lvl <= 17'h10007;
      tick(8);
      `CHK("miss irq", 1'b1, irq)
   endtask : t_irq
   task automatic finish_test;
      if (err_total == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      tick(12);
      rst_i <= 1'b0;
      tick(1);
      t_reset;
      t_pend;
      t_active;
      t_miss;
      t_fault;
      t_irq;
      finish_test;
   end
   initial begin
      tick(20000);
      err_total++;
      finish_test;
   end
endmodule : tlic_top_test
bind tlic_top tlic_top_sva tlic_top_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pending_o(pending_o));
